/* File: logic/tcc_timer_control.sv */
// three-channel timer counter control with counters and apb registers
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps

// Function
// - each of the three channels has its own identical 8-bit control reg.
// - a control register becomes 0x80 on reset and on entry to standby.
// - bit 7 of a control register ignores writes and always reads one.
// - bits 6:5 pick clearing: none, by A event, by B event, or sync clear.
// - sync clear clears the counter with the other synchronised channels.
// - an A or B clear uses compare match or capture per register function.
// - bits 4:3 pick external edges: rising, falling, or both when bit 4 set.
// - in phase counting mode channel 2 ignores its edge-select field.
// - bits 2:0 pick phi, phi/2, phi/4, phi/8, or external pins a to d.
// - with an internal source the counter steps on its falling edges only.
// - with an external source the counter steps on the selected pin edges.
// - in phase counting mode channel 2 ignores its prescaler field.
// - a selected compare match or capture clears the counter to 0x0000.
// - channel 2 counts up or down in phase mode; otherwise counters go up.
module tcc_timer_control
    import tcc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               standby,
    input  wire logic               ext_clock_pin_a,
    input  wire logic               ext_clock_pin_b,
    input  wire logic               ext_clock_pin_c,
    input  wire logic               ext_clock_pin_d,
    input  wire logic [NUM_CH-1:0]  sync_select,
    input  wire logic [NUM_CH-1:0]  gra_compare,
    input  wire logic [NUM_CH-1:0]  gra_capture,
    input  wire logic [NUM_CH-1:0]  gra_is_capture,
    input  wire logic [NUM_CH-1:0]  grb_compare,
    input  wire logic [NUM_CH-1:0]  grb_capture,
    input  wire logic [NUM_CH-1:0]  grb_is_capture,
    output logic      [NUM_CH-1:0]  count_step,
    output logic      [NUM_CH-1:0]  count_clear
);

    initial begin
        if (CNT_W < 2 || CNT_W > 32) $error("CNT_W must be 2 to 32");
    end

    logic [7:0]          ctrl [NUM_CH];
    logic [7:0]          mode_reg;
    logic [CNT_W-1:0]    channel_counter [NUM_CH];
    logic [3:0]          int_tick;
    logic [NUM_PINS-1:0] pin_lvl;
    logic [NUM_PINS-1:0] pin_rise;
    logic [NUM_PINS-1:0] pin_fall;
    logic [NUM_CH-1:0]   next_up;
    logic [NUM_CH-1:0]   next_down;
    logic [NUM_CH-1:0]   own_clear;
    logic [NUM_CH-1:0]   next_clear;
    logic                phase_count_flag;
    logic                sync_any;
    logic                quad_up;
    logic                quad_down;
    logic                wr_en;
    logic                rd_setup;
    logic                addr_ok;
    logic [31:0]         rd_mux;

    assign phase_count_flag = mode_reg[PHASE_BIT];

    // count step from the prescaler or a pin edge for one control value
    function automatic logic count_enable(
        input logic [7:0]          c,
        input logic [3:0]          it,
        input logic [NUM_PINS-1:0] rs,
        input logic [NUM_PINS-1:0] fl
    );
        logic [1:0] s;
        logic [1:0] e;
        s = c[SRC_HI-1:SRC_LO];
        e = c[EDGE_HI:EDGE_LO];
        if (!c[SRC_HI]) begin
            return it[s];
        end
        case (e)
            TCC_EDGE_RISE: return rs[s];
            TCC_EDGE_FALL: return fl[s];
            default:       return rs[s] | fl[s];
        endcase
    endfunction : count_enable

    // clear request from general register a or b for one control value
    function automatic logic gr_clear(
        input logic [7:0] c,
        input logic       a_cmp,
        input logic       a_cap,
        input logic       a_isc,
        input logic       b_cmp,
        input logic       b_cap,
        input logic       b_isc
    );
        logic a_ev;
        logic b_ev;
        a_ev = a_isc ? a_cap : a_cmp;
        b_ev = b_isc ? b_cap : b_cmp;
        case (c[CLR_HI:CLR_LO])
            TCC_CLR_GRA: return a_ev;
            TCC_CLR_GRB: return b_ev;
            default:     return 1'b0;
        endcase
    endfunction : gr_clear

    tcc_prescaler u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .standby (standby),
        .tick    (int_tick)
    );

    // pin synchroniser; every external pin count edge comes from here
    tcc_edge_sync #(
        .PINS (NUM_PINS)
    ) u_edge_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  ({ext_clock_pin_d, ext_clock_pin_c,
                   ext_clock_pin_b, ext_clock_pin_a}),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // quadrature decode of pins a and b for phase counting
    always_comb begin
        quad_up   = (pin_rise[0] && !pin_lvl[1]) ||
                    (pin_fall[0] &&  pin_lvl[1]) ||
                    (pin_rise[1] &&  pin_lvl[0]) ||
                    (pin_fall[1] && !pin_lvl[0]);
        quad_down = (pin_rise[0] &&  pin_lvl[1]) ||
                    (pin_fall[0] && !pin_lvl[1]) ||
                    (pin_rise[1] && !pin_lvl[0]) ||
                    (pin_fall[1] &&  pin_lvl[0]);
    end

    // per-channel step direction and own clear source
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            own_clear[i] = gr_clear(ctrl[i], gra_compare[i],
                                    gra_capture[i], gra_is_capture[i],
                                    grb_compare[i], grb_capture[i],
                                    grb_is_capture[i]);
            if (i == PHASE_CH && phase_count_flag) begin
                // phase counting overrides edge and source fields
                next_up[i]   = quad_up;
                next_down[i] = quad_down;
            end else begin
                next_up[i]   = count_enable(ctrl[i], int_tick,
                                            pin_rise, pin_fall);
                next_down[i] = 1'b0;
            end
        end
    end

    // a sync-selected channel clearing by its own source clears all sync-mode partners
    always_comb begin
        sync_any = |(own_clear & sync_select);
        for (int i = 0; i < NUM_CH; i++) begin
            next_clear[i] = own_clear[i] ||
                (ctrl[i][CLR_HI:CLR_LO] == TCC_CLR_SYNC &&
                 sync_select[i] && sync_any);
        end
    end

    // counters: clear beats counting, so a match never leaves a stale value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                channel_counter[i] <= CNT_W'(CNT_RESET);
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (standby || next_clear[i]) begin
                    channel_counter[i] <= CNT_W'(CNT_RESET);
                end else if (next_up[i]) begin
                    channel_counter[i] <= channel_counter[i] + 1'b1;
                end else if (next_down[i]) begin
                    channel_counter[i] <= channel_counter[i] - 1'b1;
                end
            end
        end
    end

    // registered event strobes aligned with the counter change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_step  <= '0;
            count_clear <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                count_clear[i] <= !standby && next_clear[i];
                count_step[i]  <= !standby && !next_clear[i] &&
                                  (next_up[i] || next_down[i]);
            end
        end
    end

    // apb decode: zero wait states, read data latched in the setup cycle
    assign wr_en    = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_ok;

    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (paddr)
            OFF_CTRL0: rd_mux[7:0] = ctrl[0];
            OFF_CTRL1: rd_mux[7:0] = ctrl[1];
            OFF_CTRL2: rd_mux[7:0] = ctrl[2];
            OFF_MODE:  rd_mux[7:0] = mode_reg;
            OFF_CNT0:  rd_mux[CNT_W-1:0] = channel_counter[0];
            OFF_CNT1:  rd_mux[CNT_W-1:0] = channel_counter[1];
            OFF_CNT2:  rd_mux[CNT_W-1:0] = channel_counter[2];
            default:   addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    // control registers; standby reinitialises them like a reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl[i] <= CTRL_RESET;
            end
        end else if (standby) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl[i] <= CTRL_RESET;
            end
        end else if (wr_en) begin
            case (paddr)
                OFF_CTRL0: ctrl[0] <= {1'b1, pwdata[6:0]};
                OFF_CTRL1: ctrl[1] <= {1'b1, pwdata[6:0]};
                OFF_CTRL2: ctrl[2] <= {1'b1, pwdata[6:0]};
                default: ;
            endcase
        end
    end

    // mode register holds only the phase counting flag; other bits read 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= MODE_RESET;
        end else if (standby) begin
            mode_reg <= MODE_RESET;
        end else if (wr_en && paddr == OFF_MODE) begin
            mode_reg <= {7'h00, pwdata[PHASE_BIT]};
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_RSV_BIT: assert property (
        ctrl[0][RSV_BIT] && ctrl[1][RSV_BIT] && ctrl[2][RSV_BIT])
        else $error("reserved control bit not one");

    AST_STANDBY_INIT: assert property (
        standby |=> ctrl[0] == 8'h80 && ctrl[2] == 8'h80)
        else $error("control register not 0x80 after standby");

    AST_CLEAR_A: assert property (
        !standby && ctrl[0][CLR_HI:CLR_LO] == 2'h1 && !gra_is_capture[0]
        && gra_compare[0] |=> channel_counter[0] == '0 && count_clear[0])
        else $error("compare match A did not clear counter 0");

    AST_CLEAR_CAPTURE: assert property (
        !standby && ctrl[1][CLR_HI:CLR_LO] == 2'h2 && grb_is_capture[1]
        && grb_compare[1] && !grb_capture[1] && !(|own_clear[0])
        && !sync_any |=> !count_clear[1])
        else $error("capture-mode register cleared on compare match");

    AST_SYNC_CLEAR: assert property (
        !standby && own_clear[0] && sync_select[0] && sync_select[1]
        && ctrl[1][CLR_HI:CLR_LO] == 2'h3
        |=> channel_counter[1] == '0)
        else $error("synchronised channel 1 not cleared");

    AST_PHI8_RATE: assert property (
        !standby && ctrl[0][2:0] == 3'h3 && next_up[0]
        |=> (!next_up[0] || ctrl[0][2:0] != 3'h3) [*7])
        else $error("phi/8 source stepped too often");

    AST_EXT_FALL: assert property (
        ctrl[0][2:0] == 3'h5 && ctrl[0][4:3] == 2'h1
        |-> next_up[0] == pin_fall[1])
        else $error("external falling edge select wrong");

    AST_EDGE_PULSE: assert property (
        pin_rise[2] |=> !pin_rise[2])
        else $error("pin edge enable longer than one cycle");

    AST_PHASE_IGNORE: assert property (
        phase_count_flag |-> next_up[2] == quad_up
        && next_down[2] == quad_down)
        else $error("channel 2 not following phase inputs");

    AST_UP_ONLY: assert property (
        !standby && !next_clear[0] && next_up[0]
        |=> channel_counter[0] == $past(channel_counter[0]) + 1'b1)
        else $error("channel 0 did not count up by one");

    // a write never reaches the reserved bit, the rest lands as written
    AST_WRITE_CTRL: assert property (
        !standby && psel && penable && pwrite && paddr == OFF_CTRL1
        |=> ctrl[1][RSV_BIT] && ctrl[1][6:0] == $past(pwdata[6:0]))
        else $error("control write disturbed the reserved bit");

    AST_PHI2_RATE: assert property (
        !standby && ctrl[1][2:0] == 3'h1 && next_up[1]
        |=> !next_up[1] || ctrl[1][2:0] != 3'h1)
        else $error("phi/2 source stepped on two edges in a row");

    AST_CLEAR_B_CAP: assert property (
        !standby && ctrl[2][CLR_HI:CLR_LO] == 2'h2 && grb_is_capture[2]
        && grb_capture[2] |=> channel_counter[2] == '0 && count_clear[2])
        else $error("capture B did not clear counter 2");

    AST_PHASE_UP: assert property (
        !standby && phase_count_flag && !next_clear[2] && quad_up
        |=> channel_counter[2] == $past(channel_counter[2]) + 1'b1)
        else $error("channel 2 missed a phase count up");

    AST_DOWN_STEP: assert property (
        !standby && !next_clear[2] && next_down[2] && !next_up[2]
        |=> channel_counter[2] == $past(channel_counter[2]) - 1'b1
        && count_step[2])
        else $error("channel 2 did not count down by one");

endmodule : tcc_timer_control

/* File: logic/tcc_pkg.sv */
// shared constants and types for the timer counter control block
package tcc_pkg;

    // channel and pin counts
    localparam int NUM_CH        = 3;
    localparam int NUM_PINS      = 4;
    localparam int PHASE_CH      = 2;

    // register byte offsets on the apb bus
    localparam logic [11:0] OFF_CTRL0 = 12'h000;
    localparam logic [11:0] OFF_CTRL1 = 12'h004;
    localparam logic [11:0] OFF_CTRL2 = 12'h008;
    localparam logic [11:0] OFF_MODE  = 12'h00c;
    localparam logic [11:0] OFF_CNT0  = 12'h010;
    localparam logic [11:0] OFF_CNT1  = 12'h014;
    localparam logic [11:0] OFF_CNT2  = 12'h018;

    // values after reset and standby
    localparam logic [7:0]  CTRL_RESET = 8'h80;
    localparam logic [7:0]  MODE_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET  = 16'h0000;

    // field positions inside counter_control_reg
    localparam int RSV_BIT    = 7;
    localparam int CLR_HI     = 6;
    localparam int CLR_LO     = 5;
    localparam int EDGE_HI    = 4;
    localparam int EDGE_LO    = 3;
    localparam int SRC_HI     = 2;
    localparam int SRC_LO     = 0;
    // phase_count_flag position in the mode register
    localparam int PHASE_BIT  = 0;

    // prescaler divider width (system clock up to divide by 8)
    localparam int DIV_W      = 3;

    // counter clear selection
    typedef enum logic [1:0] {
        TCC_CLR_NONE = 2'h0,
        TCC_CLR_GRA  = 2'h1,
        TCC_CLR_GRB  = 2'h2,
        TCC_CLR_SYNC = 2'h3
    } tcc_clear_t;

    // external edge selection (2'h3 also counts both edges)
    typedef enum logic [1:0] {
        TCC_EDGE_RISE = 2'h0,
        TCC_EDGE_FALL = 2'h1,
        TCC_EDGE_BOTH = 2'h2,
        TCC_EDGE_ALSO = 2'h3
    } tcc_edge_t;

endpackage : tcc_pkg

/* File: logic/tcc_prescaler.sv */
// internal clock prescaler producing falling-edge ticks of phi/1,2,4,8
`timescale 1ns/1ps
module tcc_prescaler
    import tcc_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             standby,
    output logic      [3:0]       tick
);

    logic [DIV_W-1:0] div;

    // free-running divider, held clear in standby so phases restart aligned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= '0;
        end else if (standby) begin
            div <= '0;
        end else begin
            div <= div + 3'h1;
        end
    end

    // a divided clock falls when all lower divider bits are about to wrap
    assign tick[0] = 1'b1;
    assign tick[1] = !standby && div[0];
    assign tick[2] = !standby && (&div[1:0]);
    assign tick[3] = !standby && (&div[2:0]);

endmodule : tcc_prescaler

/* File: logic/tcc_edge_sync.sv */
// synchroniser and edge detector for the external clock pins
`timescale 1ns/1ps
module tcc_edge_sync #(
    parameter int PINS = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [PINS-1:0]  pin_in,
    output logic      [PINS-1:0]  level,
    output logic      [PINS-1:0]  rise,
    output logic      [PINS-1:0]  fall
);

    logic [PINS-1:0] meta;
    logic [PINS-1:0] sync;
    logic [PINS-1:0] prev;

    initial begin
        if (PINS < 1) $error("tcc_edge_sync needs at least one pin");
    end

    // two flops against metastability, a third for the edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
        end else begin
            meta <= pin_in;
            sync <= meta;
            prev <= sync;
        end
    end

    // edges come only from settled samples, one cycle per edge
    assign level = sync;
    assign rise  = sync & ~prev;
    assign fall  = ~sync & prev;

endmodule : tcc_edge_sync

/* File: testbench/tcc_pin_model.sv */
// behavioural model of the external clock pins that feed the timer
`timescale 1ns/1ps
module tcc_pin_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic       quad,
    input  wire logic       dir,
    input  wire logic [3:0] mask,
    input  wire logic [7:0] n_edges,
    output logic      [3:0] pins,
    output logic            busy
);
    logic [7:0] left;
    logic [3:0] gap;
    logic       turn_b;

    // one pin change every sixteen cycles, slow against the synchroniser;
    // pins stand still between runs, like a real source gated off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins   <= 4'h0;
            left   <= 8'h00;
            gap    <= 4'h0;
            turn_b <= 1'b0;
        end else if (start) begin
            left   <= n_edges;
            gap    <= 4'h0;
            turn_b <= dir;
        end else if (left != 8'h00) begin
            gap <= gap + 4'h1;
            if (gap == 4'hf) begin
                left   <= left - 8'h01;
                turn_b <= ~turn_b;
                // quadrature alternates a and b; the leading pin sets direction
                if (!quad)
                    pins <= pins ^ mask;
                else if (turn_b)
                    pins[1] <= ~pins[1];
                else
                    pins[0] <= ~pins[0];
            end
        end
    end

    assign busy = (left != 8'h00);
endmodule : tcc_pin_model

/* File: testbench/timer_counter_control_bench.sv */
// self-checking bench for the timer counter control block
`timescale 1ns/1ps
module timer_counter_control_bench;
    import tcc_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, standby;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, wd, c0, c1;
    logic        pready, pslverr, err, start, quad, dir, busy, lvl;
    logic [2:0]  sync_select, gra_compare, gra_capture, gra_is_capture;
    logic [2:0]  grb_compare, grb_capture, grb_is_capture;
    logic [2:0]  count_step, count_clear;
    logic [3:0]  pins, mask;
    logic [7:0]  n_edges;
    int          n_mismatch, check_count, c, s, e, p, kind, clr, xn;
    int          steps [3] = '{0, 0, 0};
    int          snap [3];
    logic        hit;

    tcc_timer_control DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .standby(standby),
        .ext_clock_pin_a(pins[0]), .ext_clock_pin_b(pins[1]),
        .ext_clock_pin_c(pins[2]), .ext_clock_pin_d(pins[3]),
        .sync_select(sync_select), .gra_compare(gra_compare),
        .gra_capture(gra_capture), .gra_is_capture(gra_is_capture),
        .grb_compare(grb_compare), .grb_capture(grb_capture),
        .grb_is_capture(grb_is_capture), .count_step(count_step),
        .count_clear(count_clear)
    );

    tcc_pin_model pin_src (
        .pclk(pclk), .presetn(presetn), .start(start), .quad(quad),
        .dir(dir), .mask(mask), .n_edges(n_edges), .pins(pins), .busy(busy)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // tally step strobes away from the active edge to avoid races
    always @(negedge pclk)
        for (int i = 0; i < 3; i++)
            if (count_step[i] === 1'b1) steps[i]++;

    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task check(input logic [31:0] got, input logic [31:0] exp, string m);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got,
                     exp);
        end
    endtask : check

    // one apb transfer, then an idle cycle so no signal is driven twice
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            n_mismatch++;
            $display("wrong value at %0t: apb wait ran out", $time);
            finish_test();
        end
        @(posedge pclk);
    endtask : apb

    // let the pin model make n changes, bounded wait on its busy flag
    task run_pins(logic [3:0] m, logic q, logic d, logic [7:0] n);
        int k;
        mask    <= m;
        quad    <= q;
        dir     <= d;
        n_edges <= n;
        start   <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (busy && k < 400);
        if (k >= 400) begin
            n_mismatch++;
            $display("wrong value at %0t: pin run ran out", $time);
            finish_test();
        end
        repeat (8) @(posedge pclk);
    endtask : run_pins

    // one event strobe on channel ch, then the clear strobe a cycle later
    task pulse(int ch, int k, logic [2:0] exp);
        logic [2:0] b;
        b = 3'b001 << ch;
        gra_compare <= (k == 0) ? b : 3'h0;
        gra_capture <= (k == 1) ? b : 3'h0;
        grb_compare <= (k == 2) ? b : 3'h0;
        grb_capture <= (k == 3) ? b : 3'h0;
        @(posedge pclk);
        gra_compare <= 3'h0;
        gra_capture <= 3'h0;
        grb_compare <= 3'h0;
        grb_capture <= 3'h0;
        @(negedge pclk);
        check(32'(count_clear), 32'(exp), "clear strobe");
        @(posedge pclk);
    endtask : pulse

    function automatic logic [11:0] cad(int ch);
        return OFF_CTRL0 + 12'(4 * ch);
    endfunction : cad

    // edges seen on n changes starting from level l, per edge setting
    function automatic int exp_edges(logic [1:0] ed, logic l, int n);
        int r;
        r = l ? n / 2 : (n + 1) / 2;
        if (ed[1]) return n;
        return ed[0] ? n - r : r;
    endfunction : exp_edges

    initial begin
        void'($urandom(32'hf854));
        {presetn, psel, penable, pwrite, standby, start, quad, dir} = 8'h00;
        {paddr, pwdata, n_edges, mask} = 56'h0;
        {sync_select, gra_compare, gra_capture, gra_is_capture} = 12'h000;
        {grb_compare, grb_capture, grb_is_capture} = 9'h000;
        n_mismatch = 0;
        check_count = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (c = 0; c < 3; c++) begin
            apb(1'b0, cad(c), 32'h0);
            check(rd, 32'h80, "ctrl reset");
            check(32'(err), 32'h0, "ctrl err");
        end
        apb(1'b0, 12'h01c, 32'h0);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        $display("test reset done");
        // reserved top bit reads one whatever was written
        for (int i = 0; i < 9; i++) begin
            wd = $urandom;
            apb(1'b1, cad(i % 3), wd);
            apb(1'b0, cad(i % 3), 32'h0);
            check(rd, {24'h0, 1'b1, wd[6:0]}, "ctrl rw");
        end
        $display("test register done");
        // internal sources, edge field random and so ignored
        for (s = 0; s < 4; s++) begin
            for (c = 0; c < 3; c++)
                apb(1'b1, cad(c), 32'(($urandom & 3) << 3 | (s + c) % 4));
            repeat (16) @(posedge pclk);
            snap = steps;
            repeat (24) @(posedge pclk);
            for (c = 0; c < 3; c++) begin
                xn = 24 >> ((s + c) % 4);
                check(steps[c] - snap[c], xn, "phi");
            end
        end
        $display("test internal done");
        // external pins, a neighbour pin toggles too and must not count
        for (s = 4; s < 8; s++)
            for (e = 0; e < 4; e++) begin
                c = (s + e) % 3;
                p = s - 4;
                apb(1'b1, cad(c), 32'(e << 3 | s));
                for (int r = 0; r < 2; r++) begin
                    lvl = pins[p];
                    snap = steps;
                    run_pins(4'(1 << p | 1 << ((p + 1) % 4)), 1'b0, 1'b0, 5);
                    xn = exp_edges(2'(e), lvl, 5);
                    check(steps[c] - snap[c], xn, "pin");
                end
            end
        $display("test external done");
        // clear source against register function, all four event kinds
        for (int i = 0; i < 24; i++) begin
            c = $urandom % 3;
            clr = $urandom % 3;
            kind = i % 4;
            gra_is_capture <= 3'($urandom);
            grb_is_capture <= 3'($urandom);
            apb(1'b1, cad(c), 32'(clr << 5));
            hit = (clr == 1 && kind < 2 && (kind == 1) == gra_is_capture[c])
               || (clr == 2 && kind > 1 && (kind == 3) == grb_is_capture[c]);
            pulse(c, kind, hit ? 3'(1 << c) : 3'h0);
        end
        $display("test clear done");
        apb(1'b1, cad(0), 32'h20);
        apb(1'b1, cad(1), 32'h60);
        apb(1'b1, cad(2), 32'h60);
        gra_is_capture <= 3'h0;
        sync_select <= 3'b011;
        pulse(0, 0, 3'b011);
        sync_select <= 3'b110;
        pulse(0, 0, 3'b001);
        sync_select <= 3'b000;
        $display("test sync done");
        // phase mode: random ch2 fields must not matter
        apb(1'b1, OFF_MODE, 32'h1);
        apb(1'b1, cad(2), $urandom & 32'h1f);
        apb(1'b0, OFF_CNT2, 32'h0);
        c0 = rd;
        snap = steps;
        run_pins(4'h0, 1'b1, 1'b0, 8);
        apb(1'b0, OFF_CNT2, 32'h0);
        c1 = rd;
        check(32'(16'(c1 - c0)), 32'd8, "phase up");
        check(steps[2] - snap[2], 32'd8, "phase steps");
        run_pins(4'h0, 1'b1, 1'b1, 8);
        apb(1'b0, OFF_CNT2, 32'h0);
        check(32'(16'(c1 - rd)), 32'd8, "phase down");
        $display("test phase done");
        for (c = 0; c < 3; c++)
            apb(1'b1, cad(c), $urandom);
        standby <= 1'b1;
        repeat (2) @(posedge pclk);
        standby <= 1'b0;
        @(posedge pclk);
        for (c = 0; c < 3; c++) begin
            apb(1'b0, cad(c), 32'h0);
            check(rd, 32'h80, "standby");
        end
        apb(1'b0, OFF_MODE, 32'h0);
        check(rd, 32'h0, "standby mode");
        $display("test standby done");
        finish_test();
    end
endmodule : timer_counter_control_bench
